// File: pwmt_pkg.sv
`default_nettype none
package pwmt_pkg;
    // ==========================================
    // Widths
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned REG_W    = 16;
    localparam int unsigned PRESC_W  = 6;
    localparam int unsigned NUM_GEN  = 4;
    localparam int unsigned PS_W     = 4;

    // ==========================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TBC    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLKDIV = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SECMP  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_TIMER  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PHASE  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_GENCTL = 8'h18;

    // ==========================================
    // Reset values and masks
    localparam logic [REG_W-1:0]  TBC_RST        = 16'h0000;
    localparam logic [2:0]        CLKDIV_RST     = 3'h0;
    localparam logic [REG_W-1:0]  PERIOD_RST     = 16'hfff8;
    localparam logic [REG_W-1:0]  SECMP_RST      = 16'h0000;
    localparam logic [REG_W-1:0]  SECMP_MASK     = 16'hfff8;
    localparam logic [REG_W-1:0]  PHASE_RST      = 16'h0000;
    localparam logic [REG_W-1:0]  TBC_WR_MASK    = 16'hafbf;
    localparam logic [DATA_W-1:0] TBC_RSVD_MASK  = 32'hffff4040;
    localparam logic [DATA_W-1:0] CLKDIV_RSVD    = 32'hfffffff8;
    localparam int unsigned       TBC_PEND_BIT   = 12;
    localparam logic [2:0]        CLKDIV_MAX     = 3'h6;
    localparam logic [1:0]        SRC_IN1        = 2'h0;
    localparam logic [1:0]        SRC_IN2        = 2'h1;

    // ==========================================
    // Time base control layout, bit 15 down to bit 0
    typedef struct packed {
        logic       pwm_module_enable;
        logic       unused14;
        logic       idle_stop_select;
        logic       special_event_pending;
        logic       special_event_irq_enable;
        logic       immediate_period_update;
        logic       sync_polarity_invert;
        logic       sync_output_enable;
        logic       external_sync_enable;
        logic       unused6;
        logic [1:0] sync_source_select;
        logic [3:0] special_event_postscale;
    } pwmt_tbc_type;

    typedef struct packed {
        logic [NUM_GEN-1:0] high;
        logic [NUM_GEN-1:0] low;
    } pwmt_pins_type;

    typedef enum logic [1:0] {TB_OFF, TB_RUN, TB_HALT} pwmt_tb_state_type;
endpackage
`default_nettype wire

// File: pwmt_time_base.sv
// Functional notes
// (R1) Whole module runs only while enable bit 15 is set.
// (R2) Idle-stop bit set halts the time base during processor idle.
// (R3) Pending flag bit 12 set and cleared by hardware; zero when none. The code clears it when software writes 1 to bit 12.
// (R4) Special event interrupt forwarded only while bit 11 enable is set.
// (R5) Bit 10 set loads period at once; else at cycle boundary.
// (R6) Bit 9 set makes sync inputs and sync output active-low.
// (R7) Sync output driven only while bit 8 is set.
// (R8) Bit 7 set restarts the time base on selected external sync.
// (R9) Sync source 00 picks input 1, 01 input 2; others reserved.
// (R10) Postscale N gives one trigger per N+1 compare matches.
// (R11) Clock divider codes 000..110 divide by 1..64; 111 reserved.
// (R12) Software changes settings only while the module is disabled.
// (R13) Software sets period slightly above expected external sync period.
// (R14) Unimplemented control and divider bits read as zero.
// (R15) Four generators drive eight pins in high/low pairs.
// (R16) Resolution is one count of the divided time base clock.
// (R17) Push-pull alternates pulses between pair pins each cycle.
// (R18) Variable-phase generators hold 50% duty with shifted phase.
// (R19) Software loads period only within 0x0010..0xfff8.
// (R20) Compare value uses bits 15..3; bits 2..0 read zero.
// (R21) Timer counts per divided clock, restarts at period, marks boundary.
// (R22) Each trigger sets pending and requests interrupt when enabled. The code sets pending only while bit 11 is set.
//
// The register addresses and the APB interface to the registers were decided locally.
`default_nettype none

// ==========================================
// One generator pair
module pwmt_gen (
    // Clock and reset
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_reset_n,
    input  wire logic                           i_clk_en,
    // Time base
    input  wire logic                           i_run,
    input  wire logic [pwmt_pkg::REG_W-1:0]     i_timer,
    input  wire logic [pwmt_pkg::REG_W-1:0]     i_period,
    input  wire logic [pwmt_pkg::REG_W-1:0]     i_phase,
    input  wire logic                           i_push_pull,
    input  wire logic                           i_toggle,
    // Pins
    output logic                                o_high,
    output logic                                o_low
);
    import pwmt_pkg::*;
    logic              high_reg;
    logic              high_next;
    logic              low_reg;
    logic              low_next;
    logic [REG_W:0]    pos;
    logic              active;

    always_comb begin
        pos = {1'b0, i_timer} + {1'b0, i_phase};
        if (pos >= {1'b0, i_period}) begin
            pos = pos - {1'b0, i_period};
        end
        active = (pos[REG_W-1:0] < (i_period >> 1)); // [R18]
        high_next = 1'b0;
        low_next  = 1'b0;
        if (i_run) begin
            if (i_push_pull) begin
                high_next = active & i_toggle; // [R17]
                low_next  = active & ~i_toggle; // [R17]
            end else begin
                high_next = active; // [R15]
                low_next  = ~active; // [R15]
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            high_reg <= 1'b0;
            low_reg  <= 1'b0;
        end else if (i_clk_en) begin
            high_reg <= high_next;
            low_reg  <= low_next;
        end
    end

    assign o_high = high_reg;
    assign o_low  = low_reg;
endmodule

// ==========================================
// Master time base with APB registers
module pwmt_time_base (
    // Clock, reset, enable
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_reset_n,
    input  wire logic                           i_clk_en,
    // APB slave
    input  wire logic                           i_psel,
    input  wire logic                           i_penable,
    input  wire logic                           i_pwrite,
    input  wire logic [pwmt_pkg::ADDR_W-1:0]    i_paddr,
    input  wire logic [pwmt_pkg::DATA_W-1:0]    i_pwdata,
    output logic                                o_pready,
    output logic [pwmt_pkg::DATA_W-1:0]         o_prdata,
    output logic                                o_pslverr,
    // System
    input  wire logic                           i_cpu_idle,
    input  wire logic [1:0]                     i_sync_input,
    // Outputs
    output logic                                o_sync_output,
    output logic                                o_sync_output_oe,
    output logic                                o_special_event_trigger,
    output logic                                o_special_event_irq,
    output pwmt_pkg::pwmt_pins_type             o_pwm_pins
);
    import pwmt_pkg::*;

    // ==========================================
    // State
    pwmt_tbc_type        tbc_reg, tbc_next;
    logic [2:0]          clkdiv_reg, clkdiv_next;
    logic [REG_W-1:0]    shadow_reg, shadow_next;
    logic [REG_W-1:0]    active_reg, active_next;
    logic [REG_W-1:0]    secmp_reg, secmp_next;
    logic [REG_W-1:0]    phase_reg, phase_next;
    logic                pushpull_reg, pushpull_next;
    logic [REG_W-1:0]    timer_reg, timer_next;
    logic [PRESC_W-1:0]  presc_reg, presc_next;
    logic [PS_W-1:0]     ps_reg, ps_next;
    logic                toggle_reg, toggle_next;
    logic                trig_reg, trig_next;
    logic                sout_reg, sout_next;
    logic                soe_reg, soe_next;
    logic                pready_reg, pready_next;
    logic                pslverr_reg, pslverr_next;
    logic [DATA_W-1:0]   prdata_reg, prdata_next;
    pwmt_tb_state_type   state_reg, state_next;
    logic [1:0]          sync_meta_reg, sync_stable_reg;
    logic                sync_prev_reg, sync_prev_next;

    // ==========================================
    // Decode
    logic                wr_en, setup;
    logic [2:0]          eff_div;
    logic [PRESC_W-1:0]  div_mask;
    logic                tick, run, boundary, match, sync_act, sync_edge;

    assign setup    = i_psel & ~i_penable;
    assign wr_en    = i_psel & i_penable & pready_reg & i_pwrite;
    assign run      = (state_reg == TB_RUN);
    // Reserved divider code runs as the slowest setting rather than stopping
    assign eff_div  = (clkdiv_reg > CLKDIV_MAX) ? CLKDIV_MAX : clkdiv_reg; // [R11]
    assign div_mask = PRESC_W'(({1'b0, {PRESC_W{1'b0}}} + 1'b1 << eff_div) - 1'b1); // [R11]
    assign tick     = run && (presc_reg == div_mask); // [R16]
    assign boundary = tick && (timer_reg >= active_reg); // [R21]
    assign match    = tick && (timer_reg == (secmp_reg & SECMP_MASK)); // [R20]

    // Only the stable stage is read; the first stage feeds nothing else
    always_comb begin
        case (tbc_reg.sync_source_select) // [R9]
            SRC_IN1: sync_act = sync_stable_reg[0];
            SRC_IN2: sync_act = sync_stable_reg[1];
            default: sync_act = tbc_reg.sync_polarity_invert;
        endcase
        sync_act = sync_act ^ tbc_reg.sync_polarity_invert; // [R6]
    end
    assign sync_edge = run && tbc_reg.external_sync_enable && sync_act && ~sync_prev_reg; // [R8]

    // ==========================================
    // Next state
    always_comb begin
        tbc_next       = tbc_reg;
        clkdiv_next    = clkdiv_reg;
        shadow_next    = shadow_reg;
        secmp_next     = secmp_reg;
        phase_next     = phase_reg;
        pushpull_next  = pushpull_reg;
        sync_prev_next = sync_act;

        if (wr_en) begin
            case (i_paddr)
                OFS_TBC: begin
                    tbc_next = pwmt_tbc_type'((i_pwdata[REG_W-1:0] & TBC_WR_MASK)
                                   | (REG_W'(tbc_reg) & ~TBC_WR_MASK)); // [R14]
                end
                OFS_CLKDIV: clkdiv_next  = i_pwdata[2:0]; // [R11]
                OFS_PERIOD: shadow_next  = i_pwdata[REG_W-1:0];
                OFS_SECMP:  secmp_next   = i_pwdata[REG_W-1:0] & SECMP_MASK; // [R20]
                OFS_PHASE:  phase_next   = i_pwdata[REG_W-1:0];
                OFS_GENCTL: pushpull_next = i_pwdata[0];
                default: ;
            endcase
        end

        // Time base states
        if (!tbc_reg.pwm_module_enable) begin
            state_next = TB_OFF; // [R1]
        end else if (i_cpu_idle && tbc_reg.idle_stop_select) begin
            state_next = TB_HALT; // [R2]
        end else begin
            state_next = TB_RUN;
        end

        presc_next  = presc_reg;
        timer_next  = timer_reg;
        ps_next     = ps_reg;
        toggle_next = toggle_reg;
        trig_next   = 1'b0;
        case (state_reg)
            TB_OFF: begin
                presc_next  = '0; // [R1]
                timer_next  = '0; // [R1]
                ps_next     = '0;
                toggle_next = 1'b0;
            end
            TB_RUN: begin
                presc_next = tick ? '0 : PRESC_W'(presc_reg + 1'b1);
                if (sync_edge) begin
                    timer_next  = '0; // [R8]
                    presc_next  = '0;
                    toggle_next = ~toggle_reg;
                end else if (boundary) begin
                    timer_next  = '0; // [R21]
                    toggle_next = ~toggle_reg; // [R17]
                end else if (tick) begin
                    timer_next = REG_W'(timer_reg + 1'b1); // [R21]
                end
                if (match) begin
                    if (ps_reg >= tbc_reg.special_event_postscale) begin
                        ps_next   = '0; // [R10]
                        trig_next = 1'b1; // [R10]
                    end else begin
                        ps_next = PS_W'(ps_reg + 1'b1); // [R10]
                    end
                end
            end
            TB_HALT: ; // [R2]
            default: state_next = TB_OFF;
        endcase

        // Period load
        if (tbc_reg.immediate_period_update || boundary || sync_edge) begin
            active_next = shadow_reg; // [R5]
        end else begin
            active_next = active_reg; // [R5]
        end

        // Pending flag: a trigger in the clearing cycle wins
        tbc_next.special_event_pending = tbc_next.special_event_irq_enable
            & (trig_next | (tbc_reg.special_event_pending
            & ~(wr_en && (i_paddr == OFS_TBC) && i_pwdata[TBC_PEND_BIT]))); // [R3] [R4] [R22]

        // Sync output pulse at each boundary
        soe_next  = tbc_reg.sync_output_enable; // [R7]
        sout_next = tbc_reg.sync_polarity_invert
                    ^ (tbc_reg.sync_output_enable & (boundary | sync_edge)); // [R6] [R7]

        // APB answer: data prepared in setup, ready in the access cycle
        pready_next  = setup;
        pslverr_next = 1'b0;
        prdata_next  = '0;
        if (setup) begin
            case (i_paddr)
                OFS_TBC:    prdata_next = DATA_W'(tbc_reg) & ~TBC_RSVD_MASK; // [R14]
                OFS_CLKDIV: prdata_next = DATA_W'(clkdiv_reg) & ~CLKDIV_RSVD; // [R14]
                OFS_PERIOD: prdata_next = DATA_W'(shadow_reg);
                OFS_SECMP:  prdata_next = DATA_W'(secmp_reg & SECMP_MASK); // [R20]
                OFS_TIMER:  prdata_next = DATA_W'(timer_reg);
                OFS_PHASE:  prdata_next = DATA_W'(phase_reg);
                OFS_GENCTL: prdata_next = DATA_W'(pushpull_reg);
                default:    pslverr_next = 1'b1;
            endcase
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tbc_reg       <= pwmt_tbc_type'(TBC_RST);
            clkdiv_reg    <= CLKDIV_RST;
            shadow_reg    <= PERIOD_RST;
            active_reg    <= PERIOD_RST;
            secmp_reg     <= SECMP_RST;
            phase_reg     <= PHASE_RST;
            pushpull_reg  <= 1'b0;
            timer_reg     <= '0;
            presc_reg     <= '0;
            ps_reg        <= '0;
            toggle_reg    <= 1'b0;
            trig_reg      <= 1'b0;
            sout_reg      <= 1'b0;
            soe_reg       <= 1'b0;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            prdata_reg    <= '0;
            state_reg     <= TB_OFF;
            sync_prev_reg <= 1'b0;
        end else if (i_clk_en) begin
            tbc_reg       <= tbc_next;
            clkdiv_reg    <= clkdiv_next;
            shadow_reg    <= shadow_next;
            active_reg    <= active_next;
            secmp_reg     <= secmp_next;
            phase_reg     <= phase_next;
            pushpull_reg  <= pushpull_next;
            timer_reg     <= timer_next;
            presc_reg     <= presc_next;
            ps_reg        <= ps_next;
            toggle_reg    <= toggle_next;
            trig_reg      <= trig_next;
            sout_reg      <= sout_next;
            soe_reg       <= soe_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            prdata_reg    <= prdata_next;
            state_reg     <= state_next;
            sync_prev_reg <= sync_prev_next;
        end
    end

    // Pin synchroniser
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync_meta_reg   <= '0;
            sync_stable_reg <= '0;
        end else if (i_clk_en) begin
            sync_meta_reg   <= i_sync_input;
            sync_stable_reg <= sync_meta_reg;
        end
    end

    // ==========================================
    // Generators, phase steps of one phase register each
    logic [NUM_GEN-1:0] gen_high, gen_low;
    for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
        pwmt_gen pwmt_gen_i (
            .i_clk_sys   (i_clk_sys),
            .i_reset_n   (i_reset_n),
            .i_clk_en    (i_clk_en),
            .i_run       (run),
            .i_timer     (timer_reg),
            .i_period    (active_reg),
            .i_phase     (REG_W'(phase_reg * g)), // [R18]
            .i_push_pull (pushpull_reg),
            .i_toggle    (toggle_reg),
            .o_high      (gen_high[g]),
            .o_low       (gen_low[g])
        );
    end

    assign o_pwm_pins              = '{high: gen_high, low: gen_low};
    assign o_pready                = pready_reg;
    assign o_prdata                = prdata_reg;
    assign o_pslverr               = pslverr_reg;
    assign o_sync_output           = sout_reg;
    assign o_sync_output_oe        = soe_reg;
    assign o_special_event_trigger = trig_reg;
    assign o_special_event_irq     = tbc_reg.special_event_pending;

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    AST_OFF_TIMER_ZERO: assert property ( // [R1]
        i_clk_en && state_reg == TB_OFF |=> timer_reg == '0 && !o_pwm_pins.high[0])
        else $error("timer not cleared while disabled");
    AST_IDLE_HALT: assert property ( // [R2]
        i_clk_en && state_reg == TB_HALT |=> $stable(timer_reg))
        else $error("timer moved while halted in idle");
    AST_PENDING_SET: assert property ( // [R3]
        o_special_event_trigger && tbc_reg.special_event_irq_enable |-> o_special_event_irq)
        else $error("pending flag not set by trigger");
    AST_IRQ_NEEDS_ENABLE: assert property ( // [R4]
        o_special_event_irq |-> tbc_reg.special_event_irq_enable)
        else $error("interrupt raised while disabled");
    AST_IMMEDIATE_PERIOD: assert property ( // [R5]
        i_clk_en && tbc_reg.immediate_period_update |=> active_reg == $past(shadow_reg))
        else $error("immediate period not loaded");
    AST_DEFER_PERIOD: assert property ( // [R5]
        i_clk_en && !tbc_reg.immediate_period_update && !boundary && !sync_edge
        |=> $stable(active_reg))
        else $error("period loaded off boundary");
    AST_SYNC_OUT_OFF: assert property ( // [R7]
        i_clk_en && !tbc_reg.sync_output_enable
        |=> !o_sync_output_oe && o_sync_output == $past(tbc_reg.sync_polarity_invert))
        else $error("sync output active while disabled");
    AST_EXT_SYNC: assert property ( // [R8]
        i_clk_en && sync_edge |=> timer_reg == '0)
        else $error("external sync did not restart timer");
    AST_POSTSCALE: assert property ( // [R10]
        i_clk_en && match && ps_reg == tbc_reg.special_event_postscale
        |=> o_special_event_trigger ##1 !o_special_event_trigger || !i_clk_en)
        else $error("postscaled trigger missing");
    AST_WRAP: assert property ( // [R21]
        i_clk_en && boundary && !sync_edge |=> timer_reg == '0 && toggle_reg != $past(toggle_reg))
        else $error("timer did not restart at period");
    AST_RSVD_READ: assert property ( // [R14]
        o_pready && i_paddr == OFS_TBC |-> (o_prdata & TBC_RSVD_MASK) == '0)
        else $error("reserved bits read nonzero");

    COV_TRIGGER: cover property (o_special_event_trigger);
    COV_IRQ: cover property (o_special_event_irq);
    COV_EXT_SYNC: cover property (sync_edge);
    COV_IDLE: cover property (state_reg == TB_HALT);
endmodule
`default_nettype wire

// File: pwmt_sync_src.sv
`default_nettype none
module pwmt_sync_src (
    // Control
    input  wire logic       i_clk_sys,
    input  wire logic       i_fire,
    input  wire logic       i_sel,
    input  wire logic       i_active_low,
    // Pins
    output logic [1:0]      o_sync_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulse held four clocks so the two-stage synchroniser cannot miss it
    logic [2:0] hold_reg = 3'h0;
    logic       act;
    always_ff @(posedge i_clk_sys) begin
        hold_reg <= i_fire ? 3'h4 : (hold_reg != 3'h0 ? hold_reg - 3'h1 : 3'h0);
    end
    assign act = (hold_reg != 3'h0);
    // Idle at the inactive level of the chosen polarity
    assign o_sync_input = {2{i_active_low}} ^ {i_sel & act, ~i_sel & act};
endmodule
`default_nettype wire

// File: pwm_master_time_base_control_tb.sv
`default_nettype none
module pwm_master_time_base_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pwmt_pkg::*;
    // ==========================================
    // Signals
    logic                clk_sys = 1'b0;
    logic                reset_n = 1'b0;
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_idle = 1'b0;
    logic [ADDR_W-1:0]   paddr = '0;
    logic [DATA_W-1:0]   pwdata = '0, o_prdata, q, q1;
    logic                o_pready, o_pslverr, o_sync_output, o_sync_output_oe, slverr;
    logic                o_special_event_trigger, o_special_event_irq;
    logic                fire = 1'b0, sel = 1'b0, pol = 1'b0, clk_en = 1'b1;
    logic [1:0]          pp_seen;
    logic [1:0]          sync_in;
    pwmt_pins_type       o_pwm_pins;
    int                  failures = 0, tests_run = 0;

    initial forever #5 clk_sys = ~clk_sys;

    pwmt_time_base pwmt_time_base_i (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_en(clk_en),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .i_cpu_idle(cpu_idle), .i_sync_input(sync_in), .o_sync_output(o_sync_output),
        .o_sync_output_oe(o_sync_output_oe), .o_special_event_trigger(o_special_event_trigger),
        .o_special_event_irq(o_special_event_irq), .o_pwm_pins(o_pwm_pins));
    pwmt_sync_src pwmt_sync_src_i (.i_clk_sys(clk_sys), .i_fire(fire), .i_sel(sel),
        .i_active_low(pol), .o_sync_input(sync_in));

    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits on pready with a bound; no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        q = o_prdata;
        slverr = o_pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Counts clocks between two successive pulses of sync output or trigger
    task automatic gap(input bit s, input int exp);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin @(posedge clk_sys); n++; end
            while ((s ? o_special_event_trigger : o_sync_output) !== 1'b1 && n < 3000);
        end
        check(n, exp);
    endtask

    task automatic stop_test();
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #500000;
        failures++;
        stop_test();
    end

    // ==========================================
    // Tests
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(0, OFS_TBC, 0);    check(q, 0);
        apb(0, OFS_CLKDIV, 0); check(q, 0);
        apb(0, OFS_PERIOD, 0); check(q, 32'hfff8);
        apb(0, 8'hfc, 0);      check(q, 0); check(slverr, 1);
        apb(1, OFS_TBC, 32'hffff6fff); apb(0, OFS_TBC, 0); check(q, 32'h2fbf);
        repeat (2) @(posedge clk_sys);
        check({o_sync_output, o_sync_output_oe}, 2'b11);
        apb(1, OFS_TBC, 0); repeat (2) @(posedge clk_sys);
        check({o_sync_output, o_sync_output_oe}, 2'b00);
        apb(1, OFS_CLKDIV, 32'hffffffff); apb(0, OFS_CLKDIV, 0); check(q, 7);
        apb(1, OFS_SECMP, 32'hffff); apb(0, OFS_SECMP, 0); check(q, 32'hfff8);
        // Immediate update while off, so the short period is active before the first run
        apb(1, OFS_TBC, 32'h400); apb(1, OFS_PERIOD, 32'h10); apb(1, OFS_SECMP, 32'h8);
        // Divider only changed with the module off
        for (int d = 0; d < 7; d++) begin
            apb(1, OFS_TBC, 0); apb(1, OFS_CLKDIV, d); apb(1, OFS_TBC, 32'h8100);
            gap(0, 17 << d);
        end
        apb(1, OFS_TBC, 0); apb(1, OFS_CLKDIV, 0);
        for (int n = 0; n < 16; n += 15) begin
            apb(1, OFS_TBC, 0); apb(1, OFS_TBC, 32'h8800 | n);
            gap(1, 17 * (n + 1));
        end
        repeat (2) @(posedge clk_sys);
        check(o_special_event_irq, 1);
        apb(0, OFS_TBC, 0); check(q, 32'h980f);
        apb(1, OFS_TBC, 32'h980f); apb(0, OFS_TBC, 0); check(q, 32'h880f);
        apb(1, OFS_TBC, 0);
        apb(1, OFS_TBC, 32'h8000); gap(1, 17); repeat (2) @(posedge clk_sys);
        check(o_special_event_irq, 0);
        apb(1, OFS_TBC, 32'ha000); cpu_idle <= 1'b1; repeat (4) @(posedge clk_sys);
        apb(0, OFS_TIMER, 0); q1 = q; apb(0, OFS_TIMER, 0);
        check(q, q1); check(o_pwm_pins, 0);
        apb(1, OFS_TBC, 32'h8000); apb(0, OFS_TIMER, 0); q1 = q; apb(0, OFS_TIMER, 0);
        check(q != q1, 1);
        cpu_idle <= 1'b0;
        apb(1, OFS_PERIOD, 32'hfff8);
        for (int k = 0; k < 4; k++) begin
            sel <= k[0]; pol <= k[1];
            apb(1, OFS_TBC, 0); apb(1, OFS_TBC, 32'h8080 | (k[1] << 9) | (k[0] << 4));
            repeat (60) @(posedge clk_sys);
            fire <= 1'b1; @(posedge clk_sys); fire <= 1'b0;
            repeat (8) @(posedge clk_sys);
            apb(0, OFS_TIMER, 0); check(q < 16, 1);
        end
        apb(1, OFS_TBC, 0); apb(1, OFS_PHASE, 32'h8);
        apb(1, OFS_TBC, 32'h8500); apb(1, OFS_PERIOD, 32'h10);
        gap(0, 17);
        // Half-period phase step makes the second generator the inverse of the first
        repeat (34) begin
            @(posedge clk_sys);
            check(o_pwm_pins.high ^ o_pwm_pins.low, 4'hf);
            check(o_pwm_pins.high[1], !o_pwm_pins.high[0]);
        end
        // Low clock enable must hold the sync pulse train still
        clk_en <= 1'b0;
        @(posedge clk_sys);
        q1 = o_sync_output;
        repeat (40) begin
            @(posedge clk_sys);
            check(o_sync_output, q1);
        end
        clk_en <= 1'b1;
        apb(1, OFS_TBC, 0); apb(1, OFS_GENCTL, 1); apb(1, OFS_TBC, 32'h8000);
        pp_seen = '0;
        repeat (40) begin
            @(posedge clk_sys);
            check(o_pwm_pins.high & o_pwm_pins.low, 0);
            pp_seen |= {o_pwm_pins.high[0], o_pwm_pins.low[0]};
        end
        check(pp_seen, 3);
        stop_test();
    end
endmodule
`default_nettype wire
